/* bench/sixteen_bit_timer_checker.sv */
`timescale 1ns/10ps
module sixteen_bit_timer_checker
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic SRST,
    // APB slave side
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [9:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Pins
    input wire logic [timer16_pkg::CHANNELS-1:0] PORT_OUT,
    input wire logic [timer16_pkg::CHANNELS-1:0] PIN_OUT
);
    import timer16_pkg::*;
    // ----------------
    // Control shadow
    // ----------------
    typedef struct packed {
        logic [3:0] ctl_a;
        logic [6:0] ctl_b;
    } shadow_type;
    shadow_type sh_r;
    shadow_type sh_nxt;
    logic wr_commit;
    logic [7:0] idx;
    logic mapped;
    logic [2:0] wave_mask;

    // Commit, decode and wave mask
    assign wr_commit = PSEL && PENABLE && PREADY && PWRITE;
    assign idx = PADDR[9:2];
    assign mapped = idx inside {[8'h00:8'h07], IDX_TICK_COUNT, IDX_CYCLE_LEN,
        IDX_COMPARE_VALUE_0, IDX_COMPARE_VALUE_1, IDX_COMPARE_VALUE_2, IDX_CYCLE_BUF, IDX_CYCLE_BUF_HIGH,
        IDX_CMP_BUF0, IDX_CMP_BUF1, IDX_CMP_BUF2};
    assign wave_mask = (sh_r.ctl_b[2:0] != 3'h0) ? sh_r.ctl_b[6:4] : 3'h0;

    // Next shadow value
    always_comb
    begin
        sh_nxt = sh_r;
        if (wr_commit && idx == IDX_CLK_EN_CTRL)
            sh_nxt.ctl_a = PWDATA[3:0];
        if (wr_commit && idx == IDX_CMP_WAVE_CTRL)
            sh_nxt.ctl_b = PWDATA[6:0];
        if (SRST)
            sh_nxt = '0;
    end

    // Shadow register
    always_ff @(posedge REF_CLK)
        sh_r <= sh_nxt;

    // ----------------
    // Properties
    // ----------------
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SRST);

    AST_READY_AFTER_SETUP:
        assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no ready after setup");
    AST_READY_SINGLE:
        assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    AST_READY_IN_ACCESS:
        assert property (PREADY |-> PSEL && PENABLE && $past(PSEL)
            && !$past(PENABLE))
        else $error("ready outside access");
    AST_ERR_BY_MAP:
        assert property (PREADY |-> PSLVERR == !mapped)
        else $error("error flag disagrees with map");
    AST_IDLE_QUIET:
        assert property (!PREADY |-> !PSLVERR && PRDATA == 32'h0)
        else $error("answer outside access");
    AST_ERR_READS_ZERO:
        assert property (PSLVERR |-> PRDATA == 32'h0)
        else $error("unmapped read not zero");
    AST_CLK_EN_READBACK:
        assert property (PREADY && !PWRITE && idx == IDX_CLK_EN_CTRL
            |-> PRDATA == {28'h0, sh_r.ctl_a})
        else $error("clock control readback wrong");
    AST_WAVE_READBACK:
        assert property (PREADY && !PWRITE && idx == IDX_CMP_WAVE_CTRL
            |-> PRDATA == {25'h0, sh_r.ctl_b})
        else $error("wave control readback wrong");
    AST_PIN_PASS:
        assert property (!$past(SRST) |->
            ((PIN_OUT ^ $past(PORT_OUT)) & ~$past(wave_mask)) == 3'h0)
        else $error("pin lost port value");
endmodule

/* bench/tb_sixteen_bit_timer.sv */
`timescale 1ns/10ps
module tb_sixteen_bit_timer;
    import timer16_pkg::*;
    logic ref_clk;
    logic srst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [9:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] port_out;
    logic [2:0] pin_out;
    logic [31:0] rd;
    logic err;
    int failures = 0;
    int check_count = 0;

    sixteen_bit_timer u_dut
    (
        .REF_CLK(ref_clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .PORT_OUT(port_out),
        .PIN_OUT(pin_out)
    );

    // Clock
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // ----------------
    // Helpers
    // ----------------
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer, then one idle edge
    task automatic xfer(input logic wr, input logic [7:0] idx,
        input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1 && n < 16)
        begin
            n++;
            @(posedge ref_clk);
        end
        if (n == 16)
            failures++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rdc(input string what, input logic [7:0] idx,
        input logic [31:0] exp);
        xfer(1'b0, idx, 32'h0);
        check(what, rd, exp);
    endtask

    // ----------------
    // Scenarios
    // ----------------
    // Reset values, unused bits, unmapped hole
    task automatic t_regs;
        rdc("ctl_a", IDX_CLK_EN_CTRL, 32'h0);
        rdc("ctl_b", IDX_CMP_WAVE_CTRL, 32'h0);
        rdc("cyc", IDX_CYCLE_LEN, 32'hffff);
        rdc("cyc_buf", IDX_CYCLE_BUF, 32'hffff);
        rdc("compare_value_0", IDX_COMPARE_VALUE_0, 32'h0);
        xfer(1'b1, IDX_CLK_EN_CTRL, 32'hfe);
        rdc("ctl_a_rw", IDX_CLK_EN_CTRL, 32'h0e);
        xfer(1'b1, IDX_CLK_EN_CTRL, 32'h0);
        xfer(1'b1, 8'h09, 32'hff);
        check("wr_err", {31'h0, err}, 32'h1);
        rdc("hole", 8'h09, 32'h0);
        check("rd_err", {31'h0, err}, 32'h1);
    endtask

    // Ticks over eight divider periods, then hold while off
    task automatic t_div;
        int dv [8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
        int base;
        logic [31:0] was;
        for (int c = 0; c < 8; c++)
        begin
            base = (8 * dv[c] + 3) / dv[c];
            xfer(1'b1, IDX_TICK_COUNT, 32'h0);
            xfer(1'b1, IDX_CLK_EN_CTRL, {28'h0, 3'(c), 1'b1});
            repeat (8 * dv[c]) @(posedge ref_clk);
            xfer(1'b1, IDX_CLK_EN_CTRL, {28'h0, 3'(c), 1'b0});
            xfer(1'b0, IDX_TICK_COUNT, 32'h0);
            was = rd;
            check("ticks", was, base);
            repeat (20) @(posedge ref_clk);
            rdc("held", IDX_TICK_COUNT, was);
        end
    endtask

    // Wave override of port value in every wave mode except normal, which keeps the port value
    task automatic t_pins;
        logic [2:0] md [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
        port_out <= 3'b010;
        for (int m = 0; m < 6; m++)
        begin
            xfer(1'b1, IDX_CMP_WAVE_CTRL, {25'h0, 4'b1110, md[m]});
            for (int v = 0; v < 2; v++)
            begin
                xfer(1'b1, IDX_OUT_VALUE_CTRL, {29'h0, {3{v[0]}}});
                repeat (3) @(posedge ref_clk);
                check("pin", {29'h0, pin_out},
                    {29'h0, m == 0 ? 3'b010 : {3{v[0]}}});
            end
        end
        xfer(1'b1, IDX_CMP_WAVE_CTRL, {25'h0, 4'b1010, WAVE_SINGLE});
        xfer(1'b1, IDX_OUT_VALUE_CTRL, 32'h0);
        repeat (3) @(posedge ref_clk);
        check("pin_off", {29'h0, pin_out}, 32'h2);
        xfer(1'b1, IDX_CMP_WAVE_CTRL, 32'h0);
    endtask

    // Transfer hold by software, then automatic
    task automatic t_hold;
        xfer(1'b1, IDX_CMD_DIR_SET, 32'h2);
        xfer(1'b1, IDX_CMP_BUF0, 32'h1234);
        rdc("hold_sw", IDX_CMD_DIR_CLR, 32'h2);
        xfer(1'b1, IDX_CMD_DIR_SET, {28'h0, CMD_UPDATE, 2'b00});
        rdc("compare_value_0_kept", IDX_COMPARE_VALUE_0, 32'h0);
        rdc("hold_kept", IDX_CMD_DIR_CLR, 32'h2);
        xfer(1'b1, IDX_CMD_DIR_CLR, 32'h2);
        xfer(1'b1, IDX_CMD_DIR_SET, {28'h0, CMD_UPDATE, 2'b00});
        rdc("compare_value_0_moved", IDX_COMPARE_VALUE_0, 32'h1234);
        rdc("hold_low", IDX_CMD_DIR_CLR, 32'h0);
        xfer(1'b1, IDX_CMP_WAVE_CTRL, 32'h38);
        rdc("hold_auto", IDX_CMD_DIR_CLR, 32'h2);
        xfer(1'b1, IDX_CMP_BUF0, 32'h0aaa);
        rdc("hold_wait", IDX_CMD_DIR_CLR, 32'h2);
        xfer(1'b1, IDX_CMP_BUF1, 32'h0bbb);
        rdc("hold_free", IDX_CMD_DIR_CLR, 32'h0);
        xfer(1'b1, IDX_CMD_DIR_SET, {28'h0, CMD_UPDATE, 2'b00});
        rdc("compare_value_1_moved", IDX_COMPARE_VALUE_1, 32'h0bbb);
        rdc("hold_again", IDX_CMD_DIR_CLR, 32'h2);
        xfer(1'b1, IDX_CMP_WAVE_CTRL, 32'h0);
    endtask

    // Restart and hard reset commands while stopped
    task automatic t_cmd;
        xfer(1'b1, IDX_CMD_DIR_SET, {28'h0, CMD_RESTART, 2'b00});
        rdc("restart", IDX_TICK_COUNT, 32'h0);
        xfer(1'b1, IDX_CYCLE_LEN, 32'h0042);
        xfer(1'b1, IDX_CMD_DIR_SET, {28'h0, CMD_RESET, 2'b00});
        rdc("rst_hold", IDX_CMD_DIR_CLR, 32'h0);
        rdc("rst_compare_value_1", IDX_COMPARE_VALUE_1, 32'h0);
        rdc("rst_cyc", IDX_CYCLE_LEN, 32'hffff);
    endtask

    // ----------------
    // Sequence and verdict
    // ----------------
    task automatic finish_test;
        if (failures == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 10'h0;
        pwdata = 32'h0;
        port_out = 3'h0;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        t_regs();
        t_div();
        t_pins();
        t_hold();
        t_cmd();
        finish_test();
    end

    // Watchdog
    initial
    begin
        repeat (40000) @(posedge ref_clk);
        failures++;
        finish_test();
    end
endmodule

bind sixteen_bit_timer sixteen_bit_timer_checker u_chk
(
    .REF_CLK(REF_CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .PORT_OUT(PORT_OUT),
    .PIN_OUT(PIN_OUT)
);

/* hdl/sixteen_bit_timer.sv */
`timescale 1ns/10ps
// Overview of operation
// R1 - Clock-select bits 3:1 pick tick divide 1,2,4,8,16,64,256,1024.
// R2 - Bit 0 of first control register enables the timer.
// R3 - Enabled channel puts its wave output on the pin, else port value.
// R4 - Software sets the pin as output in the port block.
// R5 - Auto-hold write sets transfer hold until enabled buffers all valid.
// R6 - Then hold stays clear; next update copies buffers and sets hold.
// R7 - Without auto-hold the hardware never touches transfer hold.
// R8 - Wave mode bits 2:0 pick sequence, top, update and waveform.
// R9 - Plain counting mode makes no waveform output.
// R10 - Transfer hold blocks buffer transfer at update; clear allows it.
// R11 - Counter steps only on prescaled ticks while enabled.
module sixteen_bit_timer
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic SRST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [9:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Pins
    input wire logic [timer16_pkg::CHANNELS-1:0] PORT_OUT,
    output logic [timer16_pkg::CHANNELS-1:0] PIN_OUT
);
    import timer16_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic enable;
        logic [2:0] tick_divider_select;
        logic [CHANNELS-1:0] chan_en;
        logic auto_hold;
        logic [2:0] wave_mode;
        logic [CHANNELS-1:0] out_value;
        logic dual_sel;
        logic hold;
        logic dir;
        logic [CHANNELS:0] bv;
        logic [PRESC_W-1:0] presc;
        logic [15:0] count;
        logic [15:0] cycle_len;
        logic [15:0] cycle_buf;
        logic [CHANNELS-1:0][15:0] cmp;
        logic [CHANNELS-1:0][15:0] cmp_buf;
        logic [CHANNELS-1:0] wave;
        logic [CHANNELS-1:0] pin;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } state_type;

    state_type st_r;
    state_type st_nxt;

    // Divider mask per clock-select code
    function automatic logic [PRESC_W-1:0] div_mask(input logic [2:0] sel);
        case (sel)
            3'h0: div_mask = 10'h000;
            3'h1: div_mask = 10'h001;
            3'h2: div_mask = 10'h003;
            3'h3: div_mask = 10'h007;
            3'h4: div_mask = 10'h00f;
            3'h5: div_mask = 10'h03f;
            3'h6: div_mask = 10'h0ff;
            default: div_mask = 10'h3ff;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        logic tick;
        logic update;
        logic force_update;
        logic [15:0] top;
        logic [15:0] wd16;
        logic [7:0] wd8;
        logic setup;
        logic wr;
        logic [7:0] idx;
        logic [1:0] cmd;
        logic [CHANNELS-1:0] chan_bv;
        logic hold_set;
        tick = 1'b0;
        update = 1'b0;
        force_update = 1'b0;
        top = 16'h0000;
        wd16 = PWDATA[15:0];
        wd8 = PWDATA[7:0];
        setup = PSEL && !PENABLE;
        wr = PSEL && PENABLE && st_r.ready && PWRITE;
        idx = PADDR[9:2];
        cmd = CMD_NONE;
        chan_bv = '0;
        hold_set = 1'b0;
        st_nxt = st_r;

        // Prescaler and tick
        if (st_r.enable) // R2
        begin
            st_nxt.presc = st_r.presc + 10'h001;
            tick = (st_r.presc & div_mask(st_r.tick_divider_select))
                == div_mask(st_r.tick_divider_select); // R1
        end
        else
        begin
            st_nxt.presc = '0;
        end

        // Counting sequence per wave mode
        top = (st_r.wave_mode == WAVE_FREQ) ? st_r.cmp[0]
            : st_r.cycle_len; // R8
        if (tick) // R11
        begin
            if (st_r.wave_mode >= WAVE_DS_TOP)
            begin
                if (!st_r.dir)
                begin
                    if (st_r.count >= top)
                    begin
                        st_nxt.dir = 1'b1;
                        st_nxt.count = st_r.count - COUNT_STEP;
                    end
                    else
                    begin
                        st_nxt.count = st_r.count + COUNT_STEP;
                    end
                end
                else if (st_r.count == 16'h0000)
                begin
                    st_nxt.dir = 1'b0;
                    st_nxt.count = COUNT_STEP;
                    update = 1'b1; // R8
                end
                else
                begin
                    st_nxt.count = st_r.count - COUNT_STEP;
                end
            end
            else if (!st_r.dir)
            begin
                if (st_r.count >= top)
                begin
                    st_nxt.count = 16'h0000;
                    update = 1'b1; // R8
                end
                else
                begin
                    st_nxt.count = st_r.count + COUNT_STEP;
                end
            end
            else if (st_r.count == 16'h0000)
            begin
                st_nxt.count = top;
                update = 1'b1;
            end
            else
            begin
                st_nxt.count = st_r.count - COUNT_STEP;
            end
        end

        // Waveform generation
        for (int n = 0; n < CHANNELS; n++)
        begin
            if (!st_r.enable)
                st_nxt.wave[n] = st_r.out_value[n];
            else if (st_r.wave_mode == WAVE_FREQ)
            begin
                if (tick && st_r.count == st_r.cmp[n])
                    st_nxt.wave[n] = !st_r.wave[n];
            end
            else
                st_nxt.wave[n] = st_nxt.count < st_r.cmp[n];
            // Pin override
            if (st_r.chan_en[n] && st_r.wave_mode != WAVE_NORMAL) // R3 R9
                st_nxt.pin[n] = st_r.wave[n]; // R3
            else
                st_nxt.pin[n] = PORT_OUT[n]; // R3
        end

        // Auto hold release once enabled buffers are valid
        chan_bv = st_r.bv[CHAN_BV_LSB +: CHANNELS];
        if (st_r.auto_hold && st_r.hold
            && (chan_bv & st_r.chan_en) == st_r.chan_en) // R5
            st_nxt.hold = 1'b0; // R5

        // Software command decode
        if (wr && (idx == IDX_CMD_DIR_SET || idx == IDX_CMD_DIR_CLR))
            cmd = PWDATA[CMD_LSB +: 2];
        force_update = (cmd == CMD_UPDATE);

        // Buffer transfer at update
        if ((update || force_update) && !st_r.hold) // R10
        begin
            if (st_r.bv[CYCLE_BV_BIT])
                st_nxt.cycle_len = st_r.cycle_buf;
            for (int n = 0; n < CHANNELS; n++)
            begin
                if (st_r.bv[CHAN_BV_LSB + n])
                    st_nxt.cmp[n] = st_r.cmp_buf[n]; // R6
            end
            st_nxt.bv = '0;
            if (st_r.auto_hold) // R7
            begin
                st_nxt.hold = 1'b1; // R6
                hold_set = 1'b1;
            end
        end

        if (cmd == CMD_RESTART)
        begin
            st_nxt.count = 16'h0000;
            st_nxt.dir = 1'b0;
            st_nxt.presc = '0;
        end

        // Register writes (take effect at the access edge)
        if (wr)
        begin
            case (idx)
                IDX_CLK_EN_CTRL:
                begin
                    st_nxt.enable = wd8[ENABLE_BIT]; // R2
                    st_nxt.tick_divider_select = wd8[TICK_DIVIDER_SELECT_LSB +: 3]; // R1
                end
                IDX_CMP_WAVE_CTRL:
                begin
                    st_nxt.chan_en = wd8[CHAN_EN_LSB +: CHANNELS];
                    st_nxt.auto_hold = wd8[AUTO_HOLD_BIT];
                    st_nxt.wave_mode = wd8[WAVE_MODE_LSB +: 3]; // R8
                    if (wd8[AUTO_HOLD_BIT])
                        st_nxt.hold = 1'b1; // R5
                end
                IDX_OUT_VALUE_CTRL: st_nxt.out_value = wd8[CHANNELS-1:0];
                IDX_DUAL_CTRL: st_nxt.dual_sel = wd8[0];
                IDX_CMD_DIR_CLR:
                begin
                    // Hardware set of transfer hold beats a software clear
                    if (wd8[HOLD_BIT] && !hold_set)
                        st_nxt.hold = 1'b0;
                    if (wd8[DIR_BIT])
                        st_nxt.dir = 1'b0;
                end
                IDX_CMD_DIR_SET:
                begin
                    if (wd8[HOLD_BIT])
                        st_nxt.hold = 1'b1;
                    if (wd8[DIR_BIT])
                        st_nxt.dir = 1'b1;
                end
                IDX_BV_CLR: st_nxt.bv = st_nxt.bv & ~wd8[CHANNELS:0];
                IDX_BV_SET: st_nxt.bv = st_nxt.bv | wd8[CHANNELS:0];
                IDX_TICK_COUNT: st_nxt.count = wd16;
                IDX_CYCLE_LEN: st_nxt.cycle_len = wd16;
                IDX_COMPARE_VALUE_0: st_nxt.cmp[0] = wd16;
                IDX_COMPARE_VALUE_1: st_nxt.cmp[1] = wd16;
                IDX_COMPARE_VALUE_2: st_nxt.cmp[2] = wd16;
                IDX_CYCLE_BUF:
                begin
                    st_nxt.cycle_buf = wd16;
                    st_nxt.bv[CYCLE_BV_BIT] = 1'b1;
                end
                IDX_CYCLE_BUF_HIGH:
                begin
                    st_nxt.cycle_buf[15:8] = wd8;
                    st_nxt.bv[CYCLE_BV_BIT] = 1'b1;
                end
                IDX_CMP_BUF0:
                begin
                    st_nxt.cmp_buf[0] = wd16;
                    st_nxt.bv[CHAN_BV_LSB] = 1'b1;
                end
                IDX_CMP_BUF1:
                begin
                    st_nxt.cmp_buf[1] = wd16;
                    st_nxt.bv[CHAN_BV_LSB + 1] = 1'b1;
                end
                IDX_CMP_BUF2:
                begin
                    st_nxt.cmp_buf[2] = wd16;
                    st_nxt.bv[CHAN_BV_LSB + 2] = 1'b1;
                end
                default: st_nxt.bv = st_nxt.bv;
            endcase
        end

        // Hard reset command, ignored while enabled
        if (cmd == CMD_RESET && !st_r.enable)
        begin
            st_nxt.count = 16'h0000;
            st_nxt.dir = 1'b0;
            st_nxt.hold = 1'b0;
            st_nxt.bv = '0;
            st_nxt.cycle_len = CYCLE_LEN_RESET;
            st_nxt.cycle_buf = CYCLE_LEN_RESET;
            st_nxt.cmp = '0;
            st_nxt.cmp_buf = '0;
        end

        // APB read data, ready and error captured in setup phase
        st_nxt.ready = setup;
        st_nxt.slverr = 1'b0;
        st_nxt.rdata = 32'h0000_0000;
        if (setup)
        begin
            case (idx)
                IDX_CLK_EN_CTRL:
                    st_nxt.rdata[3:0] = {st_r.tick_divider_select, st_r.enable};
                IDX_CMP_WAVE_CTRL:
                    st_nxt.rdata[6:0] = {st_r.chan_en, st_r.auto_hold,
                        st_r.wave_mode};
                IDX_OUT_VALUE_CTRL:
                    st_nxt.rdata[CHANNELS-1:0] = st_r.out_value;
                IDX_DUAL_CTRL: st_nxt.rdata[0] = st_r.dual_sel;
                IDX_CMD_DIR_CLR, IDX_CMD_DIR_SET:
                    st_nxt.rdata[1:0] = {st_r.hold, st_r.dir};
                IDX_BV_CLR, IDX_BV_SET:
                    st_nxt.rdata[CHANNELS:0] = st_r.bv;
                IDX_TICK_COUNT: st_nxt.rdata[15:0] = st_r.count;
                IDX_CYCLE_LEN: st_nxt.rdata[15:0] = st_r.cycle_len;
                IDX_COMPARE_VALUE_0: st_nxt.rdata[15:0] = st_r.cmp[0];
                IDX_COMPARE_VALUE_1: st_nxt.rdata[15:0] = st_r.cmp[1];
                IDX_COMPARE_VALUE_2: st_nxt.rdata[15:0] = st_r.cmp[2];
                IDX_CYCLE_BUF: st_nxt.rdata[15:0] = st_r.cycle_buf;
                IDX_CYCLE_BUF_HIGH:
                    st_nxt.rdata[7:0] = st_r.cycle_buf[15:8];
                IDX_CMP_BUF0: st_nxt.rdata[15:0] = st_r.cmp_buf[0];
                IDX_CMP_BUF1: st_nxt.rdata[15:0] = st_r.cmp_buf[1];
                IDX_CMP_BUF2: st_nxt.rdata[15:0] = st_r.cmp_buf[2];
                default: st_nxt.slverr = 1'b1;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            st_r <= '0;
            // Cycle length and its buffer leave reset at all ones
            st_r.cycle_len <= CYCLE_LEN_RESET;
            st_r.cycle_buf <= CYCLE_LEN_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign PRDATA = st_r.rdata;
    assign PREADY = st_r.ready;
    assign PSLVERR = st_r.slverr;
    assign PIN_OUT = st_r.pin;

endmodule

/* hdl/timer16_pkg.sv */
package timer16_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CLK_EN_CTRL = 8'h00;
    localparam logic [7:0] IDX_CMP_WAVE_CTRL = 8'h01;
    localparam logic [7:0] IDX_OUT_VALUE_CTRL = 8'h02;
    localparam logic [7:0] IDX_DUAL_CTRL = 8'h03;
    localparam logic [7:0] IDX_CMD_DIR_CLR = 8'h04;
    localparam logic [7:0] IDX_CMD_DIR_SET = 8'h05;
    localparam logic [7:0] IDX_BV_CLR = 8'h06;
    localparam logic [7:0] IDX_BV_SET = 8'h07;
    localparam logic [7:0] IDX_TICK_COUNT = 8'h20;
    localparam logic [7:0] IDX_CYCLE_LEN = 8'h26;
    localparam logic [7:0] IDX_COMPARE_VALUE_0 = 8'h28;
    localparam logic [7:0] IDX_COMPARE_VALUE_1 = 8'h2a;
    localparam logic [7:0] IDX_COMPARE_VALUE_2 = 8'h2c;
    localparam logic [7:0] IDX_CYCLE_BUF = 8'h36;
    localparam logic [7:0] IDX_CYCLE_BUF_HIGH = 8'h37;
    localparam logic [7:0] IDX_CMP_BUF0 = 8'h38;
    localparam logic [7:0] IDX_CMP_BUF1 = 8'h3a;
    localparam logic [7:0] IDX_CMP_BUF2 = 8'h3c;

    // APB byte address of a register index
    function automatic logic [9:0] reg_addr(input logic [7:0] idx);
        reg_addr = {idx, 2'b00};
    endfunction

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ENABLE_BIT = 0;
    localparam int TICK_DIVIDER_SELECT_LSB = 1;
    localparam int WAVE_MODE_LSB = 0;
    localparam int AUTO_HOLD_BIT = 3;
    localparam int CHAN_EN_LSB = 4;
    localparam int DIR_BIT = 0;
    localparam int HOLD_BIT = 1;
    localparam int CMD_LSB = 2;
    localparam int CYCLE_BV_BIT = 0;
    localparam int CHAN_BV_LSB = 1;
    localparam int CHANNELS = 3;

    // ------------------------------------------------------------
    // Modes, commands and reset values
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        WAVE_NORMAL = 3'h0,
        WAVE_FREQ = 3'h1,
        WAVE_SINGLE = 3'h3,
        WAVE_DS_TOP = 3'h5,
        WAVE_DS_BOTH = 3'h6,
        WAVE_DS_BOTTOM = 3'h7
    } wave_mode_type;

    localparam logic [1:0] CMD_NONE = 2'h0;
    localparam logic [1:0] CMD_UPDATE = 2'h1;
    localparam logic [1:0] CMD_RESTART = 2'h2;
    localparam logic [1:0] CMD_RESET = 2'h3;

    localparam logic [15:0] CYCLE_LEN_RESET = 16'hffff;
    localparam logic [15:0] COUNT_STEP = 16'h0001;
    localparam int PRESC_W = 10;

endpackage
